//--- logic/rcs_defines.svh
// rcs_defines.svh: register indexes, field positions, reset values, timing
// assumes: included by the package and by the reset control module
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

// register indexes; byte address is four times the index
`define RCS_IDX_INDIRECT_DATA_PORT        8'h00
`define RCS_IDX_TMR         8'h01
`define RCS_IDX_PCL         8'h02
`define RCS_IDX_STAT        8'h03
`define RCS_IDX_PTR         8'h04
`define RCS_IDX_PA          8'h05
`define RCS_IDX_PB          8'h06
`define RCS_IDX_EDAT        8'h08
`define RCS_IDX_EADR        8'h09
`define RCS_IDX_PCH         8'h0a
`define RCS_IDX_ICTL        8'h0b
`define RCS_IDX_INDIRECT_DATA_PORT_M      8'h80
`define RCS_IDX_OPT         8'h81
`define RCS_IDX_PCL_M       8'h82
`define RCS_IDX_STAT_M      8'h83
`define RCS_IDX_PTR_M       8'h84
`define RCS_IDX_DIRA        8'h85
`define RCS_IDX_DIRB        8'h86
`define RCS_IDX_ECTL        8'h88
`define RCS_IDX_EUNL        8'h89
`define RCS_IDX_PCH_M       8'h8a
`define RCS_IDX_ICTL_M      8'h8b
`define RCS_IDX_WREG        8'h90
`define RCS_IDX_EVT         8'h91
`define RCS_IDX_MASK        8'h92
`define RCS_IDX_CTRL        8'h93
`define RCS_IDX_CAUSE       8'h94

// field positions
`define RCS_STAT_TO_BIT     4
`define RCS_STAT_PD_BIT     3
`define RCS_GIE_BIT         7
`define RCS_ECTL_WRERR_BIT  3
`define RCS_ECTL_WR_BIT     1
`define RCS_EVT_W           7
`define RCS_EVT_POR         0
`define RCS_EVT_CLR_RUN     1
`define RCS_EVT_CLR_SLP     2
`define RCS_EVT_WDT_RUN     3
`define RCS_EVT_WDT_WAKE    4
`define RCS_EVT_IRQ_WAKE    5
`define RCS_EVT_GLITCH      6

// reset values
`define RCS_PC_RESET        13'h0000
`define RCS_PC_VECTOR       13'h0004
`define RCS_OPT_RESET       8'hff
`define RCS_DIRA_RESET      5'h1f
`define RCS_DIRB_RESET      8'hff
`define RCS_PCH_RESET       5'h00
`define RCS_STAT_HI_MASK    8'h1f
`define RCS_ICTL_KEEP_MASK  8'h01
`define RCS_ECTL_RESET      5'h00
`define RCS_STAT_FLAG_MASK  8'h18
`define RCS_STAT_LOW_MASK   8'h07
`define RCS_STAT_CLR_SLP    8'h10
`define RCS_STAT_WDT_RUN    8'h08

// timing: clear pin filter
`define RCS_CLK_PERIOD_NS   100
`define RCS_CLR_FILT_NS     300
`define RCS_CLR_FILT_CYC    ((`RCS_CLR_FILT_NS + `RCS_CLK_PERIOD_NS - 1) / `RCS_CLK_PERIOD_NS)

`endif

//--- logic/rcs_pkg.sv
// rcs_pkg.sv: types of the reset cause and state control block
// assumes: rcs_defines.svh on the include path
package rcs_pkg;
    `include "rcs_defines.svh"

    typedef enum logic [2:0] {
        RCS_CAUSE_POR,
        RCS_CAUSE_CLR_RUN,
        RCS_CAUSE_CLR_SLEEP,
        RCS_CAUSE_WDT_RUN,
        RCS_CAUSE_WDT_WAKE,
        RCS_CAUSE_IRQ_WAKE
    } rcs_cause_t;

    typedef struct packed {
        logic [7:0]          wreg;
        logic [7:0]          tmr;
        logic [7:0]          stat;
        logic [7:0]          ptr;
        logic [4:0]          pa;
        logic [7:0]          pb;
        logic [7:0]          edat;
        logic [7:0]          eadr;
        logic [4:0]          pch;
        logic [7:0]          ictl;
        logic [7:0]          opt;
        logic [4:0]          dira;
        logic [7:0]          dirb;
        logic [4:0]          ectl;
        logic [`RCS_EVT_W-1:0] evt;
        logic [`RCS_EVT_W-1:0] mask;
        logic                rc_mode;
        rcs_cause_t          cause;
        logic                sleeping;
        logic [3:0]          filt_cnt;
        logic                clr_filt;
        logic                hold;
        logic [1:0]          div_cnt;
        logic                clkout;
        logic                pc_load;
        logic [12:0]         pc_val;
        logic [31:0]         prdata;
    } rcs_state_t;
endpackage

//--- logic/rcs_reset_ctrl.sv
// rcs_reset_ctrl.sv: reset cause detection, special register reset states,
// wake-up handling and rc clock-out divider behind an apb slave
// assumes: all inputs synchronous to mclk_i; rstn_i low marks power-on
//
// Summary of operation
// - classify six reset kinds, handle each distinctly
// - filter clear pin, ignore short glitches
// - undefined registers keep contents on every reset, power-on too
// - reset states on resets, not watchdog or irq wake
// - rc mode drives clock-out at clock/4
// - power-on: pc zero, flags 0001_1xxx
// - clear in run: pc zero, 000u_uuuu
// - clear in sleep: pc zero, 0001_0uuu
// - watchdog in run: pc zero, 0000_1uuu
// - watchdog wake: pc+1, flags both cleared
// - irq wake: flags 1/0, pc+1 or vector
// - flags reflect cause; software reads them
// - option/direction ones, latch zero, irq control
// - power-on never leaves either flag clear
// - every reset but watchdog wake clears global irq enable
`timescale 1ns/1ns
`include "rcs_defines.svh"

module rcs_reset_ctrl
    import rcs_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [9:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // reset sources and core status
    input  wire logic        ext_clear_pin_n_i,
    input  wire logic        watchdog_timer_timeout_i,
    input  wire logic        sleep_enter_i,
    input  wire logic        irq_wake_i,
    input  wire logic [12:0] pc_i,
    // core control
    output logic             core_hold_o,
    output logic             pc_load_o,
    output logic      [12:0] pc_load_value_o,
    output logic             sleeping_o,
    output logic      [7:0]  processor_flags_o,
    // clock out and interrupt
    output logic             clock_out_pin_o,
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // state

    rcs_state_t r;
    rcs_state_t next_r;

    logic [7:0] idx;
    logic       wr_acc;
    logic       rd_setup;
    logic       mapped;
    logic       clr_raw;
    logic       clr_fall;
    logic [7:0] wb;

    assign idx      = paddr_i[9:2];
    assign wr_acc   = psel_i & penable_i & pwrite_i;
    assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
    assign clr_raw  = ~ext_clear_pin_n_i;
    assign wb       = pwdata_i[7:0];

    ////////////////////////////////////////////////////////////////////////
    // address decode

    always_comb begin
        unique case (idx)
            `RCS_IDX_INDIRECT_DATA_PORT, `RCS_IDX_TMR, `RCS_IDX_PCL, `RCS_IDX_STAT,
            `RCS_IDX_PTR, `RCS_IDX_PA, `RCS_IDX_PB, `RCS_IDX_EDAT,
            `RCS_IDX_EADR, `RCS_IDX_PCH, `RCS_IDX_ICTL, `RCS_IDX_INDIRECT_DATA_PORT_M,
            `RCS_IDX_OPT, `RCS_IDX_PCL_M, `RCS_IDX_STAT_M, `RCS_IDX_PTR_M,
            `RCS_IDX_DIRA, `RCS_IDX_DIRB, `RCS_IDX_ECTL, `RCS_IDX_EUNL,
            `RCS_IDX_PCH_M, `RCS_IDX_ICTL_M, `RCS_IDX_WREG, `RCS_IDX_EVT,
            `RCS_IDX_MASK, `RCS_IDX_CTRL, `RCS_IDX_CAUSE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // common reset state of the special registers

    // loads what every non-wake reset loads; undefined registers untouched
    function automatic rcs_state_t apply_reset(input rcs_state_t s, input logic por);
        rcs_state_t t;
        t         = s;
        t.opt     = `RCS_OPT_RESET;
        t.dira    = `RCS_DIRA_RESET;
        t.dirb    = `RCS_DIRB_RESET;
        t.pch     = `RCS_PCH_RESET;
        t.ictl    = s.ictl & `RCS_ICTL_KEEP_MASK;
        t.ectl    = `RCS_ECTL_RESET;
        // an interrupted eeprom write leaves its error flag behind
        if (!por) begin
            t.ectl[`RCS_ECTL_WRERR_BIT] = s.ectl[`RCS_ECTL_WR_BIT];
        end
        t.pc_val   = `RCS_PC_RESET;
        t.pc_load  = 1'b1;
        t.sleeping = 1'b0;
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_r         = r;
        next_r.pc_load = 1'b0;
        clr_fall       = 1'b0;

        // rc clock-out divider, parked outside rc mode so the first pulse is whole
        next_r.div_cnt = r.rc_mode ? r.div_cnt + 2'd1 : 2'd0;
        next_r.clkout  = r.rc_mode & next_r.div_cnt[1];

        // clear pin glitch filter
        if (clr_raw != r.clr_filt) begin
            if (r.filt_cnt == 4'(`RCS_CLR_FILT_CYC - 1)) begin
                next_r.clr_filt = clr_raw;
                next_r.filt_cnt = 4'd0;
                clr_fall        = clr_raw;
            end else begin
                next_r.filt_cnt = r.filt_cnt + 4'd1;
            end
        end else begin
            next_r.filt_cnt = 4'd0;
            if (r.filt_cnt != 4'd0 && !r.clr_filt) begin
                next_r.evt[`RCS_EVT_GLITCH] = 1'b1;
            end
        end
        next_r.hold = next_r.clr_filt;

        // software access, lowest priority
        if (wr_acc) begin
            unique case (idx)
                `RCS_IDX_TMR: next_r.tmr = wb;
                `RCS_IDX_PCL, `RCS_IDX_PCL_M: begin
                    next_r.pc_val  = {r.pch, wb};
                    next_r.pc_load = 1'b1;
                end
                // flags are read only to software
                `RCS_IDX_STAT, `RCS_IDX_STAT_M:
                    next_r.stat = (wb & ~`RCS_STAT_FLAG_MASK)
                                | (r.stat & `RCS_STAT_FLAG_MASK);
                `RCS_IDX_PTR, `RCS_IDX_PTR_M: next_r.ptr = wb;
                `RCS_IDX_PA:   next_r.pa   = wb[4:0];
                `RCS_IDX_PB:   next_r.pb   = wb;
                `RCS_IDX_EDAT: next_r.edat = wb;
                `RCS_IDX_EADR: next_r.eadr = wb;
                `RCS_IDX_PCH, `RCS_IDX_PCH_M: next_r.pch = wb[4:0];
                `RCS_IDX_ICTL, `RCS_IDX_ICTL_M: next_r.ictl = wb;
                `RCS_IDX_OPT:  next_r.opt  = wb;
                `RCS_IDX_DIRA: next_r.dira = wb[4:0];
                `RCS_IDX_DIRB: next_r.dirb = wb;
                `RCS_IDX_ECTL: next_r.ectl = wb[4:0];
                `RCS_IDX_WREG: next_r.wreg = wb;
                // a glitch that newly sets its bit in this cycle survives the clear
                `RCS_IDX_EVT:  next_r.evt  = (r.evt & ~wb[`RCS_EVT_W-1:0])
                                           | (next_r.evt & ~r.evt);
                `RCS_IDX_MASK: next_r.mask = wb[`RCS_EVT_W-1:0];
                `RCS_IDX_CTRL: next_r.rc_mode = wb[0];
                default: ;
            endcase
        end

        // core enters sleep: power-down flag cleared, timeout flag set
        if (sleep_enter_i && !r.sleeping && !r.hold) begin
            next_r.sleeping                 = 1'b1;
            next_r.stat[`RCS_STAT_TO_BIT]   = 1'b1;
            next_r.stat[`RCS_STAT_PD_BIT]   = 1'b0;
        end

        // reset and wake events, highest first; sets win over software clears
        if (clr_fall) begin
            next_r = apply_reset(next_r, 1'b0);
            if (r.sleeping) begin
                next_r.stat  = (r.stat & `RCS_STAT_LOW_MASK) | `RCS_STAT_CLR_SLP;
                next_r.cause = RCS_CAUSE_CLR_SLEEP;
                next_r.evt[`RCS_EVT_CLR_SLP] = 1'b1;
            end else begin
                next_r.stat  = r.stat & `RCS_STAT_HI_MASK;
                next_r.cause = RCS_CAUSE_CLR_RUN;
                next_r.evt[`RCS_EVT_CLR_RUN] = 1'b1;
            end
        end else if (watchdog_timer_timeout_i && !r.hold) begin
            if (r.sleeping) begin
                // wake resumes execution; registers left alone
                next_r.sleeping = 1'b0;
                next_r.stat[`RCS_STAT_TO_BIT] = 1'b0;
                next_r.stat[`RCS_STAT_PD_BIT] = 1'b0;
                next_r.pc_val  = pc_i + 13'd1;
                next_r.pc_load = 1'b1;
                next_r.cause   = RCS_CAUSE_WDT_WAKE;
                next_r.evt[`RCS_EVT_WDT_WAKE] = 1'b1;
            end else begin
                next_r = apply_reset(next_r, 1'b0);
                next_r.stat  = (r.stat & `RCS_STAT_LOW_MASK) | `RCS_STAT_WDT_RUN;
                next_r.cause = RCS_CAUSE_WDT_RUN;
                next_r.evt[`RCS_EVT_WDT_RUN] = 1'b1;
            end
        end else if (irq_wake_i && r.sleeping && !r.hold) begin
            next_r.sleeping = 1'b0;
            next_r.stat[`RCS_STAT_TO_BIT] = 1'b1;
            next_r.stat[`RCS_STAT_PD_BIT] = 1'b0;
            next_r.pc_load = 1'b1;
            if (r.ictl[`RCS_GIE_BIT]) begin
                next_r.pc_val = `RCS_PC_VECTOR;
                next_r.ictl[`RCS_GIE_BIT] = 1'b0;
            end else begin
                next_r.pc_val = pc_i + 13'd1;
            end
            next_r.cause = RCS_CAUSE_IRQ_WAKE;
            next_r.evt[`RCS_EVT_IRQ_WAKE] = 1'b1;
        end

        // power-on overrides all; x-state registers keep whatever they hold
        if (!rstn_i) begin
            next_r = apply_reset(r, 1'b1);
            next_r.stat     = {3'b000, 1'b1, 1'b1, r.stat[2:0]};
            next_r.cause    = RCS_CAUSE_POR;
            next_r.evt      = `RCS_EVT_W'(1) << `RCS_EVT_POR;
            next_r.mask     = '0;
            next_r.rc_mode  = 1'b0;
            next_r.filt_cnt = 4'd0;
            next_r.clr_filt = 1'b0;
            next_r.hold     = 1'b1;
            next_r.div_cnt  = 2'd0;
            next_r.clkout   = 1'b0;
            next_r.prdata   = 32'h0000_0000;
        end else if (rd_setup) begin
            next_r.prdata = 32'h0000_0000;
            unique case (idx)
                `RCS_IDX_TMR: next_r.prdata[7:0] = r.tmr;
                `RCS_IDX_PCL, `RCS_IDX_PCL_M: next_r.prdata[7:0] = pc_i[7:0];
                `RCS_IDX_STAT, `RCS_IDX_STAT_M: next_r.prdata[7:0] = r.stat;
                `RCS_IDX_PTR, `RCS_IDX_PTR_M: next_r.prdata[7:0] = r.ptr;
                `RCS_IDX_PA:   next_r.prdata[4:0] = r.pa;
                `RCS_IDX_PB:   next_r.prdata[7:0] = r.pb;
                `RCS_IDX_EDAT: next_r.prdata[7:0] = r.edat;
                `RCS_IDX_EADR: next_r.prdata[7:0] = r.eadr;
                `RCS_IDX_PCH, `RCS_IDX_PCH_M: next_r.prdata[4:0] = r.pch;
                `RCS_IDX_ICTL, `RCS_IDX_ICTL_M: next_r.prdata[7:0] = r.ictl;
                `RCS_IDX_OPT:  next_r.prdata[7:0] = r.opt;
                `RCS_IDX_DIRA: next_r.prdata[4:0] = r.dira;
                `RCS_IDX_DIRB: next_r.prdata[7:0] = r.dirb;
                `RCS_IDX_ECTL: next_r.prdata[4:0] = r.ectl;
                `RCS_IDX_WREG: next_r.prdata[7:0] = r.wreg;
                `RCS_IDX_EVT:  next_r.prdata[`RCS_EVT_W-1:0] = r.evt;
                `RCS_IDX_MASK: next_r.prdata[`RCS_EVT_W-1:0] = r.mask;
                `RCS_IDX_CTRL: next_r.prdata[0] = r.rc_mode;
                `RCS_IDX_CAUSE: next_r.prdata[2:0] = r.cause;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers: one synchronous process, reset handled above

    always_ff @(posedge mclk_i) begin
        r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign pready_o          = psel_i & penable_i;
    assign pslverr_o         = psel_i & penable_i & ~mapped;
    assign prdata_o          = r.prdata;
    assign core_hold_o       = r.hold;
    assign pc_load_o         = r.pc_load;
    assign pc_load_value_o   = r.pc_val;
    assign sleeping_o        = r.sleeping;
    assign processor_flags_o = r.stat;
    assign clock_out_pin_o   = r.clkout;
    assign irq_o             = |(r.evt & r.mask);

endmodule

//--- tb/rcs_reset_ctrl_properties.sv
// rcs_reset_ctrl_properties.sv: port checker of the reset control block
// assumes: bound to rcs_reset_ctrl, one clock domain on mclk_i
`timescale 1ns/1ns

module rcs_reset_ctrl_properties (
    // clock, reset and inputs
    input wire logic        mclk_i,
    input wire logic        rstn_i,
    input wire logic        ext_clear_pin_n_i,
    input wire logic        watchdog_timer_timeout_i,
    input wire logic        irq_wake_i,
    input wire logic [12:0] pc_i,
    // outputs watched
    input wire logic        core_hold_o,
    input wire logic        pc_load_o,
    input wire logic [12:0] pc_load_value_o,
    input wire logic        sleeping_o,
    input wire logic [7:0]  processor_flags_o,
    input wire logic        clock_out_pin_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    por_flags_a: assert property ($rose(rstn_i) |-> core_hold_o && pc_load_o
        && pc_load_value_o == 13'h0 && processor_flags_o[7:3] == 5'b00011)
        else $error("power-on state wrong");
    clr_filter_a: assert property ($rose(core_hold_o) |-> !$past(ext_clear_pin_n_i)
        && !$past(ext_clear_pin_n_i, 2) && !$past(ext_clear_pin_n_i, 3))
        else $error("clear taken too early");
    clr_run_a: assert property ($rose(core_hold_o) && !$past(sleeping_o) |-> pc_load_o
        && pc_load_value_o == 13'h0 && processor_flags_o[7:5] == 3'b000
        && processor_flags_o[4:3] == $past(processor_flags_o[4:3]))
        else $error("clear in run wrong");
    clr_sleep_a: assert property ($rose(core_hold_o) && $past(sleeping_o) |-> pc_load_o
        && pc_load_value_o == 13'h0 && processor_flags_o[7:3] == 5'b00010)
        else $error("clear in sleep wrong");
    wdt_run_a: assert property (watchdog_timer_timeout_i && !sleeping_o && !core_hold_o
        |=> pc_load_o && pc_load_value_o == 13'h0 && processor_flags_o[7:3] == 5'b00001)
        else $error("watchdog reset wrong");
    wdt_wake_a: assert property (watchdog_timer_timeout_i && sleeping_o && !core_hold_o
        |=> pc_load_o && pc_load_value_o == $past(pc_i) + 13'h1
        && processor_flags_o[4:3] == 2'b00 && processor_flags_o[7:5] == $past(processor_flags_o[7:5]))
        else $error("watchdog wake wrong");
    irq_wake_a: assert property (irq_wake_i && sleeping_o && !core_hold_o
        && !watchdog_timer_timeout_i |=> pc_load_o && processor_flags_o[4:3] == 2'b10
        && (pc_load_value_o == 13'h4 || pc_load_value_o == $past(pc_i) + 13'h1))
        else $error("interrupt wake wrong");
    clkout_div_a: assert property ($rose(clock_out_pin_o) |=> clock_out_pin_o
        ##1 !clock_out_pin_o ##1 !clock_out_pin_o)
        else $error("clock out not divided by four");

    cover property ($rose(core_hold_o));
    cover property (watchdog_timer_timeout_i && sleeping_o);
    cover property ($rose(clock_out_pin_o));
endmodule

bind rcs_reset_ctrl rcs_reset_ctrl_properties u_props (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .ext_clear_pin_n_i(ext_clear_pin_n_i),
    .watchdog_timer_timeout_i(watchdog_timer_timeout_i), .irq_wake_i(irq_wake_i),
    .pc_i(pc_i), .core_hold_o(core_hold_o), .pc_load_o(pc_load_o),
    .pc_load_value_o(pc_load_value_o), .sleeping_o(sleeping_o),
    .processor_flags_o(processor_flags_o), .clock_out_pin_o(clock_out_pin_o)
);

//--- tb/rcs_clr_switch.sv
// rcs_clr_switch.sv: external clear push-button with pull-up
// assumes: go and length change just after a rising clock edge
`timescale 1ns/1ns

module rcs_clr_switch (
    // clock and press control
    input  wire logic       mclk_i,
    input  wire logic       go_i,
    input  wire logic [3:0] len_i,
    // pin towards the block
    output logic            pin_n_o
);
    logic [3:0] cnt = 4'h0;

    always @(posedge mclk_i) begin
        if (go_i) begin
            cnt <= len_i;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
    // released pin is pulled up
    assign pin_n_o = (cnt == 4'h0);
endmodule

//--- tb/reset_cause_state_control_tb.sv
// reset_cause_state_control_tb.sv: self-checking bench of the reset control block
// assumes: package, clear switch model and checker compiled before it
`timescale 1ns/1ns
`include "rcs_defines.svh"

module reset_cause_state_control_tb;
    logic        mclk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [9:0]  paddr_i = 10'h0;
    logic [31:0] pwdata_i = 32'h0;
    logic [2:0]  pulse_v = 3'h0;
    logic [12:0] pc_i = 13'h0;
    logic        sw_go = 1'b0;
    logic [3:0]  sw_len = 4'h0;
    logic        pin_n, pready_o, pslverr_o, core_hold_o, pc_load_o, sleeping_o;
    logic        clock_out_pin_o, irq_o, err_seen, last;
    logic [31:0] prdata_o, rnd, w_val, t_val;
    logic [12:0] pc_load_value_o;
    logic [7:0]  processor_flags_o;
    logic [63:0] exp_q[$];
    logic [63:0] note;
    int          errors = 0;
    int          checked = 0;
    int          rises;

    always #50 mclk_i = ~mclk_i;

    rcs_reset_ctrl u_dut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_clear_pin_n_i(pin_n),
        .watchdog_timer_timeout_i(pulse_v[0]), .sleep_enter_i(pulse_v[1]),
        .irq_wake_i(pulse_v[2]), .pc_i(pc_i), .core_hold_o(core_hold_o),
        .pc_load_o(pc_load_o), .pc_load_value_o(pc_load_value_o), .sleeping_o(sleeping_o),
        .processor_flags_o(processor_flags_o), .clock_out_pin_o(clock_out_pin_o),
        .irq_o(irq_o)
    );
    rcs_clr_switch u_sw (.mclk_i(mclk_i), .go_i(sw_go), .len_i(sw_len), .pin_n_o(pin_n));

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic tend(input string name);
        $display("test %s finished at %0t ns", name, $time);
    endtask

    // apb master; reads leave their expectation for the monitor
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] data,
                       input logic [31:0] mask);
        int n;
        if (!wr) begin
            exp_q.push_back({mask, data & mask});
        end
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= {idx, 2'b00};
        pwdata_i <= data;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        err_seen = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (pready_o !== 1'b1) begin
            errors++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] data);
        apb(1'b1, idx, data, 32'h0);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] mask);
        apb(1'b0, idx, exp, mask);
    endtask

    task automatic pulse(input logic [2:0] v);
        @(posedge mclk_i);
        pulse_v <= v;
        @(posedge mclk_i);
        pulse_v <= 3'h0;
    endtask

    task automatic press(input logic [3:0] len);
        @(posedge mclk_i);
        sw_len <= len;
        sw_go <= 1'b1;
        @(posedge mclk_i);
        sw_go <= 1'b0;
    endtask

    // wait for the program counter load, then for the hold to drop
    task automatic wait_load(input logic [12:0] expv);
        int n;
        n = 0;
        while (pc_load_o !== 1'b1 && n < 40) begin
            @(posedge mclk_i);
            n++;
        end
        check({19'h0, pc_load_value_o}, {19'h0, expv});
        while (core_hold_o !== 1'b0 && n < 40) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 40) begin
            errors++;
            stop_test();
        end
    endtask

    always @(posedge mclk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            check(prdata_o & note[63:32], note[31:0]);
        end
    end

    ////////////////////////////////////////////////////////////
    initial begin
        rnd = 32'h8dcd;
        repeat (6) @(posedge mclk_i);
        rstn_i <= 1'b1;
        rd(`RCS_IDX_OPT, 32'hff, 32'hff);
        rd(`RCS_IDX_DIRA, 32'h1f, 32'h1f);
        rd(`RCS_IDX_DIRB, 32'hff, 32'hff);
        rd(`RCS_IDX_PCH_M, 32'h0, 32'h1f);
        rd(`RCS_IDX_STAT_M, 32'h18, 32'hf8);
        rd(`RCS_IDX_ICTL, 32'h0, 32'hfe);
        rd(`RCS_IDX_CAUSE, 32'h0, 32'h7);
        rd(8'h07, 32'h0, 32'hffffffff);
        check({31'h0, err_seen}, 32'h1);
        tend("power-on");
        press(4'h2);
        repeat (6) begin
            @(posedge mclk_i);
            check({31'h0, core_hold_o}, 32'h0);
        end
        rd(`RCS_IDX_EVT, 32'h40, 32'h40);
        check({31'h0, irq_o}, 32'h0);
        wr(`RCS_IDX_MASK, 32'h40);
        repeat (2) @(posedge mclk_i);
        check({31'h0, irq_o}, 32'h1);
        wr(`RCS_IDX_EVT, 32'h40);
        repeat (2) @(posedge mclk_i);
        check({31'h0, irq_o}, 32'h0);
        tend("glitch");
        rnd = lfsr(rnd);
        w_val = rnd & 32'hff;
        rnd = lfsr(rnd);
        t_val = rnd & 32'hff;
        wr(`RCS_IDX_WREG, w_val);
        wr(`RCS_IDX_TMR, t_val);
        wr(`RCS_IDX_DIRB, 32'h0);
        wr(`RCS_IDX_ICTL, 32'h81);
        pulse(3'b001);
        wait_load(13'h0);
        rd(`RCS_IDX_STAT, 32'h08, 32'hf8);
        rd(`RCS_IDX_DIRB, 32'hff, 32'hff);
        rd(`RCS_IDX_WREG, w_val, 32'hff);
        rd(`RCS_IDX_TMR, t_val, 32'hff);
        rd(`RCS_IDX_ICTL, 32'h01, 32'hff);
        rd(`RCS_IDX_CAUSE, 32'h3, 32'h7);
        wr(`RCS_IDX_STAT, 32'he7);
        rd(`RCS_IDX_STAT, 32'he8, 32'hf8);
        wr(`RCS_IDX_ECTL, 32'h02);
        press(4'h6);
        wait_load(13'h0);
        rd(`RCS_IDX_STAT, 32'h08, 32'hf8);
        rd(`RCS_IDX_CAUSE, 32'h1, 32'h7);
        rd(`RCS_IDX_ECTL, 32'h08, 32'h1f);
        tend("run resets");
        pulse(3'b010);
        @(posedge mclk_i);
        check({31'h0, sleeping_o}, 32'h1);
        press(4'h6);
        wait_load(13'h0);
        rd(`RCS_IDX_STAT, 32'h10, 32'hf8);
        rd(`RCS_IDX_CAUSE, 32'h2, 32'h7);
        rnd = lfsr(rnd);
        pc_i <= rnd[12:0];
        wr(`RCS_IDX_OPT, 32'h5a);
        wr(`RCS_IDX_STAT, 32'ha0);
        pulse(3'b010);
        pulse(3'b001);
        wait_load(rnd[12:0] + 13'h1);
        rd(`RCS_IDX_STAT, 32'ha0, 32'hf8);
        rd(`RCS_IDX_OPT, 32'h5a, 32'hff);
        rd(`RCS_IDX_CAUSE, 32'h4, 32'h7);
        for (int g = 0; g < 2; g++) begin
            wr(`RCS_IDX_ICTL, g[0] ? 32'h80 : 32'h0);
            pulse(3'b010);
            pulse(3'b100);
            wait_load(g[0] ? 13'h4 : rnd[12:0] + 13'h1);
            rd(`RCS_IDX_STAT, 32'hb0, 32'hf8);
            rd(`RCS_IDX_ICTL, 32'h0, 32'h80);
            rd(`RCS_IDX_CAUSE, 32'h5, 32'h7);
        end
        rd(`RCS_IDX_EVT, 32'h30, 32'h30);
        tend("sleep and wake");
        wr(`RCS_IDX_CTRL, 32'h1);
        repeat (4) @(posedge mclk_i);
        last = clock_out_pin_o;
        rises = 0;
        repeat (16) begin
            @(posedge mclk_i);
            if (clock_out_pin_o === 1'b1 && last === 1'b0) begin
                rises++;
            end
            last = clock_out_pin_o;
        end
        check(rises, 32'd4);
        rstn_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rstn_i <= 1'b1;
        wait_load(13'h0);
        rd(`RCS_IDX_STAT, 32'h18, 32'hf8);
        rd(`RCS_IDX_OPT, 32'hff, 32'hff);
        tend("clock out and second power-on");
        stop_test();
    end
endmodule
